// File: include/sasm_pkg.sv
// ==========================================
// Stereo audio serial master constants
package sasm_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CLKDIV = 8'h04;
	localparam logic [7:0] ADDR_FMT = 8'h08;
	localparam logic [7:0] ADDR_TX = 8'h0C;
	localparam logic [7:0] ADDR_RX = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	// ==========================================
	// Control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_WSINV_BIT = 4;
	localparam int CTRL_SCKCONT_BIT = 5;
	localparam int CTRL_IRQEN_BIT = 6;
	localparam logic [6:0] CTRL_RST = 7'h00;
	// Framing modes
	localparam logic [1:0] MODE_I2S = 2'h0;
	localparam logic [1:0] MODE_LJ = 2'h1;
	localparam logic [1:0] MODE_RJ = 2'h2;
	// ==========================================
	// Format fields
	localparam int FMT_ABITS_LSB = 0;
	localparam int FMT_PAD16_BIT = 5;
	localparam int FMT_XPAD_BIT = 6;
	localparam int FMT_XBITS_LSB = 8;
	localparam logic [12:0] FMT_RST = 13'h0010;
	localparam logic [5:0] AUDIO_MAX = 6'h10;
	localparam logic [5:0] XPAD_MAX = 6'h10;
	// ==========================================
	// Bit clock timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCK_DEF_NS = 1000;
	localparam logic [6:0] DIV_RST = 7'(SCK_DEF_NS / CLK_PERIOD_NS);
	localparam logic [6:0] DIV_MIN = 7'h02;
	localparam logic [6:0] DIV_MASK = 7'h7E;
	// Frame states
	typedef enum logic [1:0] {S_IDLE, S_ARM, S_RUN} sasm_state_t;
endpackage : sasm_pkg

// File: hdl/sasm_bitclk.sv
`timescale 1ns/1ps
// ==========================================
// Bit clock divider with edge pulses
module sasm_bitclk (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic run, // Clock runs while high
	input wire logic [5:0] half, // Half period in hclk cycles
	output logic sck_ff, // Bit clock level
	output logic rise_ff, // Pulse with sck rise
	output logic fall_ff // Pulse with sck fall
);
	logic [5:0] cnt_ff;
	wire wrap = (cnt_ff == half - 6'h01);
	// Stopped clock parks low so a gated frame starts clean
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= 6'h00;
			sck_ff <= 1'b0;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				cnt_ff <= 6'h00;
				sck_ff <= 1'b0;
				rise_ff <= 1'b0;
				fall_ff <= 1'b0;
			end else begin
				cnt_ff <= wrap ? 6'h00 : cnt_ff + 6'h01;
				sck_ff <= wrap ? ~sck_ff : sck_ff;
				rise_ff <= wrap & ~sck_ff;
				fall_ff <= wrap & sck_ff;
			end
		end
	end
	// ==========================================
	// Checks
	a_half_period: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(ce && run && $stable(half) && rise_ff) |->
		(cnt_ff == 6'h00))
		else $error("bit clock edge off its count");
endmodule : sasm_bitclk

// File: hdl/sasm_top.sv
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Master of four-wire link: data in, data out, word select, bit clock.
// - Word select high for right, low for left; polarity bit swaps them.
// - Bit clock divided from the system clock by a programmable divisor.
// - Shift out and sample in during the same bit clock cycles.
// - Up to 16 audio bits; optional zero fill up to 16.
// - Slot may grow to 32 bits with enabled zero padding beyond 16.
// - Left slot first, then right; audio bits MSB first.
// - Both slots always sent; unused slot carries what software loads.
// - I2S word select idles right, drops before left, rises before right.
// - I2S MSB one bit clock after the word select edge; padding after.
// - Left-justified idles right level, toggles at each slot start.
// - Left-justified MSB in the same cycle as the word select edge.
// - Right-justified idles left, toggles around right channel data.
// - Right-justified padding precedes audio; right MSB on the edge.
// - Divisor even, 2 to 126; default gives a 1 MHz bit clock.
// - Bit clock runs continuously or only during frames.
// - Interrupt pulse after each completed frame when enabled.
module sasm_top (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic ce, // Clock enable, freezes all
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Response, always OKAY
	output logic sck, // Bit clock pin
	output logic word_sel, // Word select pin
	output logic serial_audio_out, // Serial data out
	input wire logic serial_audio_in, // Serial data in, async
	output logic irq // Frame done pulse
);
	import sasm_pkg::*;
	// ==========================================
	// Registers
	logic [6:0] ctrl_ff;
	logic [6:0] div_ff;
	logic [12:0] fmt_ff;
	logic [31:0] tx_ff;
	logic [31:0] rx_ff;
	logic [31:0] hrdata_ff;
	logic ph_wr_ff;
	logic [7:0] ph_addr_ff;
	logic busy_ff;
	logic irq_ff;
	logic ws_ff;
	logic sdo_ff;
	logic sdi_s1_ff;
	logic sdi_s2_ff;
	logic [6:0] pos_ff;
	sasm_state_t st_ff;
	logic sck_i;
	logic rise_i;
	logic fall_i;
	// ==========================================
	// Configuration decode
	wire [1:0] mode = ctrl_ff[CTRL_MODE_LSB +: 2];
	wire is_i2s = (mode == MODE_I2S);
	wire is_rj = (mode == MODE_RJ);
	wire ws_inv = ctrl_ff[CTRL_WSINV_BIT];
	wire sck_cont = ctrl_ff[CTRL_SCKCONT_BIT];
	wire pad16 = fmt_ff[FMT_PAD16_BIT];
	wire xpad = fmt_ff[FMT_XPAD_BIT];
	wire [5:0] abits_raw = {1'b0, fmt_ff[FMT_ABITS_LSB +: 5]};
	wire [5:0] xbits_raw = {1'b0, fmt_ff[FMT_XBITS_LSB +: 5]};
	// Out of range sizes fall back to the maximum
	wire [5:0] abits = (abits_raw == 6'h00 || abits_raw > AUDIO_MAX) ?
		AUDIO_MAX : abits_raw;
	wire [5:0] xbits = (xbits_raw > XPAD_MAX) ? XPAD_MAX : xbits_raw;
	// Extra padding only stacks on top of a full 16 bit slot
	wire [5:0] slot = ((pad16 | xpad) ? AUDIO_MAX : abits) +
		(xpad ? xbits : 6'h00);
	wire [5:0] lead = is_i2s ? 6'h01 : 6'h00;
	wire [6:0] frame_len = {slot, 1'b0} + {1'b0, lead};
	wire [6:0] last_pos = frame_len - 7'h01;
	// Idle word select: right for I2S and left-justified, left for RJ
	wire ws_idle = (is_rj ? 1'b0 : 1'b1) ^ ws_inv;
	// ==========================================
	// Per bit position framing: {ws_right, audio, right, idx}
	function automatic logic [6:0] slot_map(input logic [6:0] p);
		logic [5:0] q;
		logic rgt;
		logic [5:0] k;
		logic aud;
		logic [5:0] idx;
		logic wsr;
		q = 6'(p - {1'b0, lead});
		rgt = (q >= slot);
		k = rgt ? q - slot : q;
		if (is_rj) begin
			aud = (k >= slot - abits);
			idx = slot - 6'h01 - k;
			wsr = rgt & aud;
		end else begin
			aud = (k < abits);
			idx = abits - 6'h01 - k;
			wsr = is_i2s ? (p >= slot) : rgt;
		end
		slot_map = {wsr, aud, rgt, idx[3:0]};
	endfunction : slot_map
	// Next position to present and the one on the pins now
	wire [6:0] vpos = (st_ff == S_ARM) ? 7'h00 : pos_ff + 7'h01;
	wire [6:0] vmap = slot_map(vpos);
	wire [6:0] cmap = slot_map(pos_ff);
	wire [3:0] vbit = vmap[3:0];
	wire v_aud = vmap[5];
	wire v_rgt = vmap[4];
	wire [4:0] v_sel = {v_rgt, vbit};
	wire v_tx = v_aud & tx_ff[v_sel];
	wire c_aud = cmap[5];
	wire [4:0] c_sel = {cmap[4], cmap[3:0]};
	// ==========================================
	// Bus decode
	wire ap_go = hsel & htrans[1] & hready;
	wire wr_ctrl = ph_wr_ff && ph_addr_ff == ADDR_CTRL;
	wire wr_div = ph_wr_ff && ph_addr_ff == ADDR_CLKDIV;
	wire wr_fmt = ph_wr_ff && ph_addr_ff == ADDR_FMT;
	wire wr_tx = ph_wr_ff && ph_addr_ff == ADDR_TX;
	wire [7:0] ra = haddr[7:0];
	// Unmapped addresses read zero
	wire [31:0] rd_word = (ra == ADDR_CTRL) ? {25'h0, ctrl_ff} :
		(ra == ADDR_CLKDIV) ? {25'h0, div_ff} :
		(ra == ADDR_FMT) ? {19'h0, fmt_ff} :
		(ra == ADDR_TX) ? tx_ff :
		(ra == ADDR_RX) ? rx_ff :
		(ra == ADDR_STAT) ? {31'h0, busy_ff} : 32'h0;
	// Start only when enabled and no frame is under way
	wire start = wr_ctrl & hwdata[CTRL_START_BIT] &
		hwdata[CTRL_EN_BIT] & (st_ff == S_IDLE);
	// Odd divisors round down to even; below two clamps to two
	wire [6:0] div_even = hwdata[6:0] & DIV_MASK;
	wire [6:0] nxt_div = (div_even < DIV_MIN) ? DIV_MIN : div_even;
	// ==========================================
	// Frame sequencer events
	wire clk_run = sck_cont | (st_ff == S_RUN);
	wire present = (st_ff == S_ARM) ? (sck_cont ? fall_i : 1'b1) :
		((st_ff == S_RUN) & fall_i);
	wire smp = (st_ff == S_RUN) & rise_i;
	wire done = smp & (pos_ff == last_pos);
	// ==========================================
	// Bit clock generator
	sasm_bitclk u_bitclk (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.run(clk_run),
		.half(div_ff[6:1]),
		.sck_ff(sck_i),
		.rise_ff(rise_i),
		.fall_ff(fall_i)
	);
	// ==========================================
	// Bus address phase and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr_ff <= 1'b0;
			ph_addr_ff <= 8'h00;
			hrdata_ff <= 32'h0;
		end else if (ce) begin
			ph_wr_ff <= ap_go & hwrite;
			ph_addr_ff <= ra;
			hrdata_ff <= (ap_go & ~hwrite) ? rd_word : hrdata_ff;
		end
	end
	// Software registers; start bit is never stored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= CTRL_RST;
			div_ff <= DIV_RST;
			fmt_ff <= FMT_RST;
			tx_ff <= 32'h0;
		end else if (ce) begin
			if (wr_ctrl) ctrl_ff <= hwdata[6:0] & 7'h7D;
			if (wr_div) div_ff <= nxt_div;
			if (wr_fmt) fmt_ff <= hwdata[12:0] & 13'h1F7F;
			if (wr_tx) tx_ff <= hwdata;
		end
	end
	// ==========================================
	// Input pin synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sdi_s1_ff <= 1'b0;
			sdi_s2_ff <= 1'b0;
		end else if (ce) begin
			sdi_s1_ff <= serial_audio_in;
			sdi_s2_ff <= sdi_s1_ff;
		end
	end
	// ==========================================
	// Frame state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= S_IDLE;
			busy_ff <= 1'b0;
			pos_ff <= 7'h00;
		end else if (ce) begin
			case (st_ff)
				S_IDLE: begin
					if (start) begin
						st_ff <= S_ARM;
						busy_ff <= 1'b1;
					end
				end
				S_ARM: begin
					if (present) begin
						st_ff <= S_RUN;
						pos_ff <= 7'h00;
					end
				end
				S_RUN: begin
					if (done) begin
						st_ff <= S_IDLE;
						busy_ff <= 1'b0;
					end else if (present) begin
						pos_ff <= vpos;
					end
				end
				default: st_ff <= S_IDLE;
			endcase
		end
	end
	// ==========================================
	// Pin drive: data and word select change on sck fall, the first bit of a gated frame at start; idle levels return at the last sck rise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ws_ff <= 1'b1;
			sdo_ff <= 1'b0;
		end else if (ce) begin
			if (present) begin
				ws_ff <= vmap[6] ^ ws_inv;
				sdo_ff <= v_tx;
			end else if (st_ff == S_IDLE || done) begin
				ws_ff <= ws_idle;
				sdo_ff <= 1'b0;
			end
		end
	end
	// ==========================================
	// Receive capture on sck rise; padding bits dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_ff <= 32'h0;
		end else if (ce) begin
			if (start) rx_ff <= 32'h0;
			else if (smp && c_aud) rx_ff[c_sel] <= sdi_s2_ff;
		end
	end
	// Interrupt pulse at frame end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff <= 1'b0;
		end else if (ce) begin
			irq_ff <= done & ctrl_ff[CTRL_IRQEN_BIT];
		end
	end
	// ==========================================
	// Outputs
	assign hrdata = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign sck = sck_i;
	assign word_sel = ws_ff;
	assign serial_audio_out = sdo_ff;
	assign irq = irq_ff;
	// ==========================================
	// Checks
	sequence s_last_bit;
		ce && done;
	endsequence
	sequence s_back_idle;
		!busy_ff && st_ff == S_IDLE && ws_ff == $past(ws_idle);
	endsequence
	a_frame_end: assert property (@(posedge hclk)
		disable iff (!hresetn) s_last_bit |=> s_back_idle)
		else $error("frame did not end cleanly");
	a_busy_start: assert property (@(posedge hclk)
		disable iff (!hresetn) (ce && start) |=> busy_ff ##0
		st_ff == S_ARM)
		else $error("start did not raise busy");
	a_irq_pulse: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(ce && done && ctrl_ff[CTRL_IRQEN_BIT]) |=> irq ##1 !irq || !ce)
		else $error("interrupt not a single pulse");
	a_no_irq_off: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(ce && !ctrl_ff[CTRL_IRQEN_BIT]) |=> !irq)
		else $error("interrupt while disabled");
	a_pad_zero: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(st_ff == S_RUN && !c_aud && $stable(pos_ff)) |-> !sdo_ff)
		else $error("padding bit not zero");
	a_lj_left: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(st_ff == S_RUN && mode == MODE_LJ && pos_ff < slot
		&& $stable(pos_ff) && $stable(ctrl_ff)) |-> ws_ff == ws_inv)
		else $error("left slot word select wrong");
	a_i2s_lead: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(st_ff == S_RUN && is_i2s && pos_ff == 6'h00 && $stable(pos_ff))
		|-> !sdo_ff && ws_ff == ws_inv)
		else $error("I2S lead bit wrong");
	a_sck_gated: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(ce && !sck_cont && st_ff == S_IDLE) |=> !sck)
		else $error("gated bit clock ran while idle");
	a_div_even: assert property (@(posedge hclk)
		disable iff (!hresetn) !div_ff[0] && div_ff >= DIV_MIN)
		else $error("divisor odd or too small");
	a_smp_in_run: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(ce && st_ff == S_RUN && rise_i) |-> $past(sck_i) == 1'b0)
		else $error("sample not on a rising edge");
endmodule : sasm_top

// File: verif/sasm_codec.sv
`timescale 1ns/1ps
// ==========================================
// Codec model: samples on sck rise, shifts on sck fall
module sasm_codec (
	input wire logic sck, // Bit clock from the port
	input wire logic word_sel, // Word select from the port
	input wire logic serial_audio_out, // Data from the port
	output logic serial_audio_in // Data to the port
);
	logic [63:0] pat;
	logic [64:0] ws_q;
	logic [64:0] dq;
	int n;
	// Start a new capture; first bit stands before the first rise
	task automatic arm(input logic [63:0] p);
		pat = p;
		n = 0;
		serial_audio_in = p[0];
	endtask : arm
	initial begin
		pat = 64'h0;
		n = 0;
		serial_audio_in = 1'b0;
	end
	// One frame position per rise, sampled like a real receiver
	always @(posedge sck) begin
		if (n < 65) begin
			ws_q[n] = word_sel;
			dq[n] = serial_audio_out;
		end
		n = n + 1;
	end
	// Next bit on the fall; keeps changing past the pattern end
	always @(negedge sck) begin
		serial_audio_in = pat[n % 64];
	end
endmodule : sasm_codec

// File: verif/stereo_audio_serial_master_test.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the audio serial master
module stereo_audio_serial_master_test;
	import sasm_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, ce_in;
	logic sck, word_sel, serial_audio_out, serial_audio_in;
	logic [31:0] haddr, hwdata, hrdata, rd, rng;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int mismatches, check_count, irqs, per, cyc, last, i;
	sasm_top dut (.hclk, .hresetn, .ce(ce_in), .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .sck, .word_sel, .serial_audio_out,
		.serial_audio_in, .irq);
	sasm_codec codec (.sck, .word_sel, .serial_audio_out,
		.serial_audio_in);
	// ==========================================
	// Clock, cycle count, irq pulses and bit clock period
	always #5 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc = cyc + 1;
		if (irq === 1'b1) irqs = irqs + 1;
	end
	always @(posedge sck) begin
		per = cyc - last;
		last = cyc;
	end
	// ==========================================
	// Helpers
	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	task check(input string what, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// Single word transfer; read data lands in rd
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	// One frame with expected wire and receive values worked out here
	task automatic frame(input logic [1:0] m, input logic inv,
		input logic [4:0] a, input logic p16, xp, input logic [4:0] xb,
		input logic [6:0] div, input logic ie);
		int s, l, k, j, ch, aud;
		logic ew, ed;
		logic [31:0] tx, c, exrx;
		logic [63:0] pat;
		s = p16 ? 16 : int'(a);
		if (xp) s += xb;
		l = (m == MODE_I2S) ? 2 * s + 1 : 2 * s;
		tx = xs();
		pat = {xs(), xs()};
		c = {25'h0, ie, 1'b0, inv, m, 1'b0, 1'b1};
		ahb(1'b1, ADDR_CLKDIV, {25'h0, div});
		ahb(1'b1, ADDR_FMT, {19'h0, xb, 1'b0, xp, p16, a});
		ahb(1'b1, ADDR_TX, tx);
		ahb(1'b1, ADDR_CTRL, c);
		codec.arm(pat);
		irqs = 0;
		ahb(1'b1, ADDR_CTRL, c | 32'h2);
		ahb(1'b0, ADDR_STAT, 32'h0);
		check("busy", rd, 32'h1);
		ahb(1'b1, ADDR_CTRL, c | 32'h2);
		k = 0;
		do begin
			ahb(1'b0, ADDR_STAT, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 3000);
		check("busy end", rd, 32'h0);
		repeat (2 * div) @(posedge hclk);
		check("rises", codec.n, l);
		exrx = 32'h0;
		for (k = 0; k < l; k++) begin
			aud = -1;
			if (m == MODE_I2S) begin
				j = (k - 1) % s;
				ch = (k > s);
				ew = (k >= s);
				if (k > 0 && j < a) aud = a - 1 - j;
			end else begin
				j = k % s;
				ch = (k >= s);
				ew = ch;
				if (m != MODE_RJ && j < a) aud = a - 1 - j;
				if (m == MODE_RJ && j >= s - a) aud = s - 1 - j;
				if (m == MODE_RJ) ew = ch && aud >= 0;
			end
			ed = (aud >= 0) ? tx[16 * ch + aud] : 1'b0;
			check("ws", codec.ws_q[k], ew ^ inv);
			check("dout", codec.dq[k], ed);
			if (aud >= 0) exrx[16 * ch + aud] = pat[k];
		end
		check("ws idle", word_sel, (m != MODE_RJ) ^ inv);
		check("sck park", sck, 1'b0);
		check("period", per, {25'h0, div & DIV_MASK});
		ahb(1'b0, ADDR_RX, 32'h0);
		check("rx", rd, exrx);
		check("irq", irqs, ie);
	endtask : frame
	// ==========================================
	// Main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		ce_in = 1'b1;
		rng = 32'hFF1A;
		{mismatches, check_count, irqs, per, cyc, last} = '0;
		repeat (10) @(posedge hclk);
		check("rst ws", word_sel, 1'b1);
		hresetn <= 1'b1;
		ahb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl", rd, 32'h0);
		ahb(1'b0, ADDR_CLKDIV, 32'h0);
		check("div", rd, 32'd100);
		ahb(1'b0, ADDR_FMT, 32'h0);
		check("fmt", rd, 32'h10);
		ahb(1'b0, 8'h20, 32'h0);
		check("unmapped", rd, 32'h0);
		// I2S frames keep normal polarity
		frame(MODE_I2S, 1'b0, 5'd16, 1'b0, 1'b0, 5'd0, 7'd100, 1'b1);
		frame(MODE_LJ, 1'b1, 5'd3, 1'b0, 1'b0, 5'd0, 7'd9, 1'b0);
		frame(MODE_RJ, 1'b0, 5'd12, 1'b1, 1'b1, 5'd8, 7'd8, 1'b1);
		frame(MODE_RJ, 1'b1, 5'd5, 1'b1, 1'b0, 5'd0, 7'd6, 1'b0);
		frame(2'h3, 1'b0, 5'd16, 1'b1, 1'b1, 5'd16, 7'd6, 1'b1);
		for (i = 0; i < 4; i++) begin
			rd = xs();
			frame(2'(rd[1:0] % 3), rd[1:0] % 3 != 0 && rd[2],
				5'(rd[7:4] + 1),
				1'b1, rd[3], 5'(rd[11:8] + 1), 7'd8, rd[12]);
		end
		ahb(1'b1, ADDR_CTRL, 32'h21);
		codec.arm(64'h0);
		repeat (60) @(posedge hclk);
		check("free sck", codec.n > 0, 1'b1);
		// Clock enable low must freeze the running bit clock
		ce_in <= 1'b0;
		@(posedge hclk);
		codec.arm(64'h0);
		repeat (60) @(posedge hclk);
		check("frozen sck", codec.n, 32'h0);
		ce_in <= 1'b1;
		ahb(1'b1, ADDR_CTRL, 32'h1);
		repeat (20) @(posedge hclk);
		codec.arm(64'h0);
		repeat (60) @(posedge hclk);
		check("gated sck", codec.n, 32'h0);
		stop_test();
	end
	// Watchdog well beyond the longest run
	initial begin
		#400000;
		mismatches++;
		stop_test();
	end
endmodule : stereo_audio_serial_master_test
